// *** src/mst_memory_self_test.sv ***
// Purpose: march LR memory self-test engine of the debug service unit
// Assumes: memory answers a read one cycle after the edge that takes o_mem_rd
// Notes:   command and control bits are plain ports, one-cycle pulses
//
// What this block does
// - protected external start refused, sets protection error
// - first element writes zero to every bit
// - element two: descending read zero, write one
// - element three: ascending r1 w0 r0 w1
// - element four: ascending read one, write zero
// - element five: ascending r0 w1 r1 w0
// - final element reads whole range expecting zero
// - soft reset aborts a running test
// - done flag set when test finishes
// - mode zero: stop at fault or success, done
// - mode one: halt on fault, defect only
// - paused test resumes when defect flag written one
// - fault captures address of failing word
// - fault captures phase, and bit position outside the final element
// - phase codes zero fill, one-six, seven final
// - offsets classify external and internal access
// - protected external: only full-range crc, no test
// - protected external reset-extension clear ignored, error
// - start commands discarded while a test runs
`timescale 1ns/1ns

module mst_memory_self_test #(
  parameter int W  = 32,
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // commands and configuration
  input  wire logic          i_start,
  input  wire logic          i_soft_reset,
  input  wire logic          i_clear_defect,
  input  wire logic          i_crst_set,
  input  wire logic          i_crst_clear,
  input  wire logic [12:0]   i_cmd_offset,
  input  wire logic          i_protected,
  input  wire logic [AW-1:0] i_start_addr,
  input  wire logic [AW-1:0] i_length,
  input  wire logic [1:0]    i_mode,
  // status and fault location
  output logic               o_busy,
  output logic               o_done,
  output logic               o_defect,
  output logic               o_perr,
  output logic               o_cpu_reset_ext,
  output logic               o_crc_restricted,
  output logic [AW-1:0]      o_fail_addr,
  output logic [31:0]        o_fail_data,
  // memory under test
  output logic               o_mem_rd,
  output logic               o_mem_wr,
  output logic [AW-1:0]      o_mem_addr,
  output logic [W-1:0]       o_mem_wdata,
  input  wire logic [W-1:0]  i_mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int OFS = $clog2(W / 8);
  localparam int CW  = AW - OFS;
  localparam int BW  = $clog2(W);

  // the whole engine state: one register copy and one next-state copy
  typedef struct packed {
    mst_pkg::mst_fsm_e   fsm;
    logic [2:0]          elem;
    logic [CW-1:0]       word;
    logic [CW-1:0]       count;
    logic [AW-1:0]       base;
    logic [BW-1:0]       bitn;
    logic                pair;
    logic                pause_mode;
    logic [W-1:0]        data;
    mst_pkg::mst_flags_s flags;
    logic                busy;
    logic                crc_restricted;
    logic [AW-1:0]       fail_addr;
    logic [31:0]         fail_data;
    logic                mem_rd;
    logic                mem_wr;
    logic [AW-1:0]       mem_addr;
    logic [W-1:0]        mem_wdata;
  } mst_core_s;

  localparam mst_core_s CORE_RST = '0;

  mst_core_s r;
  mst_core_s next_r;

  logic is_ext;
  logic is_int;
  logic prot_ext;

  ////////////////////////////////////////////////////////////////////////////
  // access classification; internal accesses are never restricted
  // offsets between the two ranges are left unrestricted as well
  always_comb begin
    is_ext   = (i_cmd_offset >= mst_pkg::OFS_EXT_LO)
               && (i_cmd_offset <= mst_pkg::OFS_EXT_HI);
    is_int   = (i_cmd_offset <= mst_pkg::OFS_INT_HI);
    prot_ext = i_protected && is_ext && !is_int;
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte address of the current word; start addresses are taken as aligned
  function automatic logic [AW-1:0] word_addr(input mst_core_s s);
    return s.base + (AW'(s.word) << OFS);
  endfunction

  // success and exit-on-error both leave through here
  function automatic mst_core_s finish(input mst_core_s s);
    mst_core_s t;
    t            = s;
    t.flags.done = 1'b1;
    t.busy       = 1'b0;
    t.fsm        = mst_pkg::ST_IDLE;
    return t;
  endfunction

  // steps to the next word of the element, or to the next element
  function automatic mst_core_s next_word(input mst_core_s s);
    mst_core_s t;
    logic      desc;
    logic      last;
    t    = s;
    // only the second element walks down; it ends on word zero
    desc = (s.elem == mst_pkg::EL_DN_R0W1);
    last = desc ? (s.word == '0) : (s.word == s.count - CW'(1));
    t.bitn = '0;
    t.pair = 1'b0;
    t.fsm  = mst_pkg::ST_READ;
    if (!last) begin
      t.word = desc ? s.word - CW'(1) : s.word + CW'(1);
    end else if (s.elem == mst_pkg::EL_FINAL) begin
      t = finish(s);
    end else begin
      t.elem = s.elem + 3'(1);
      t.word = '0;
    end
    return t;
  endfunction

  // after a write: second pair, next bit of the word, or next word
  function automatic mst_core_s next_step(input mst_core_s s);
    mst_core_s t;
    t     = s;
    t.fsm = mst_pkg::ST_READ;
    // a two-pair element repeats read and write on the same bit first
    if (!s.pair && mst_pkg::two_pairs(s.elem)) begin
      t.pair = 1'b1;
    end else if (s.bitn != BW'(W - 1)) begin
      t.pair = 1'b0;
      t.bitn = s.bitn + BW'(1);
    end else begin
      t = next_word(s);
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic          expect_val;
  logic          bad;
  logic [2:0]    phase;
  logic [31:0]   fault_word;
  logic [CW-1:0] req_words;

  always_comb begin
    expect_val = mst_pkg::first_val(r.elem) ^ r.pair;
    phase      = (r.elem == mst_pkg::EL_FINAL) ? mst_pkg::PH_FINAL
                 : mst_pkg::phase_base(r.elem) + {2'h0, r.pair};
    if (r.elem == mst_pkg::EL_FINAL) begin
      bad = |i_mem_rdata;
    end else begin
      bad = i_mem_rdata[r.bitn] != expect_val;
    end
    fault_word = mst_pkg::FD_RST;
    fault_word[mst_pkg::FD_PH_LSB +: mst_pkg::FD_PH_W] = phase;
    if (r.elem != mst_pkg::EL_FINAL) begin
      fault_word[mst_pkg::FD_BI_LSB +: mst_pkg::FD_BI_W] =
        mst_pkg::FD_BI_W'(r.bitn);
    end
    // length bits below one word are dropped rather than rounded up
    req_words = CW'(i_length >> OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r                = r;
    next_r.mem_rd         = 1'b0;
    next_r.mem_wr         = 1'b0;
    next_r.crc_restricted = prot_ext;

    // reset-extension clear from a protected external access is ignored
    if (i_crst_clear) begin
      if (prot_ext) begin
        next_r.flags.perr = 1'b1;
      end else begin
        next_r.flags.crst = 1'b0;
      end
    end
    // a set from the reset controller wins over a clear in the same cycle
    if (i_crst_set) begin
      next_r.flags.crst = 1'b1;
    end

    // write one clears the defect flag; in pause it also resumes
    // a fault found in this same cycle still sets it below: set wins
    if (i_clear_defect && r.fsm != mst_pkg::ST_PAUSE) begin
      next_r.flags.defect = 1'b0;
    end

    unique case (r.fsm)
      mst_pkg::ST_IDLE: begin
        if (i_start) begin
          if (prot_ext) begin
            next_r.flags.perr = 1'b1;
          end else begin
            next_r.flags.done   = 1'b0;
            next_r.flags.defect = 1'b0;
            next_r.flags.perr   = 1'b0;
            next_r.base         = i_start_addr;
            next_r.count        = req_words;
            next_r.pause_mode   = (i_mode == mst_pkg::MODE_PAUSE);
            next_r.elem         = mst_pkg::EL_FILL;
            next_r.word         = '0;
            next_r.bitn         = '0;
            next_r.pair         = 1'b0;
            next_r.busy         = 1'b1;
            next_r.fsm          = mst_pkg::ST_FILL;
            // an empty range finishes at once and touches no memory
            if (req_words == '0) begin
              next_r = finish(next_r);
            end
          end
        end
      end
      // zero fill never fails, so no read-back here
      mst_pkg::ST_FILL: begin
        next_r.mem_wr    = 1'b1;
        next_r.mem_addr  = word_addr(r);
        next_r.mem_wdata = '0;
        if (r.word == r.count - CW'(1)) begin
          next_r.elem = mst_pkg::EL_DN_R0W1;
          next_r.word = r.count - CW'(1);
          next_r.fsm  = mst_pkg::ST_READ;
        end else begin
          next_r.word = r.word + CW'(1);
        end
      end
      // the check state looks at the read data two cycles from here
      mst_pkg::ST_READ: begin
        next_r.mem_rd   = 1'b1;
        next_r.mem_addr = word_addr(r);
        next_r.fsm      = mst_pkg::ST_WAIT;
      end
      // read strobe is out this cycle; the data lands in the next
      mst_pkg::ST_WAIT: begin
        next_r.fsm = mst_pkg::ST_CHECK;
      end
      mst_pkg::ST_CHECK: begin
        next_r.data = i_mem_rdata;
        if (bad) begin
          next_r.fail_addr    = word_addr(r);
          next_r.fail_data    = fault_word;
          next_r.flags.defect = 1'b1;
          if (r.pause_mode) begin
            next_r.fsm = mst_pkg::ST_PAUSE;
          end else begin
            next_r = finish(next_r);
          end
        end else if (r.elem == mst_pkg::EL_FINAL) begin
          // the final element checks whole words and never writes
          next_r = next_word(next_r);
        end else begin
          next_r.fsm = mst_pkg::ST_WRITE;
        end
      end
      // write back the word with only the bit under test changed
      // hazard: a stuck bit elsewhere in the word is copied back into the array;
      // it is still caught when its own bit comes up
      mst_pkg::ST_WRITE: begin
        next_r.mem_wr             = 1'b1;
        next_r.mem_addr           = word_addr(r);
        next_r.mem_wdata          = r.data;
        next_r.mem_wdata[r.bitn]  = !expect_val;
        next_r                    = next_step(next_r);
      end
      // fault location stays frozen until the operator clears the defect
      // resuming into the write state puts its strobe two cycles after the clear
      mst_pkg::ST_PAUSE: begin
        if (i_clear_defect) begin
          next_r.flags.defect = 1'b0;
          if (r.elem == mst_pkg::EL_FINAL) begin
            next_r = next_word(next_r);
          end else begin
            next_r.fsm = mst_pkg::ST_WRITE;
          end
        end
      end
      default: begin
        next_r.fsm  = mst_pkg::ST_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
    // starts outside idle fall through untouched

    // soft reset overrides everything above, a fresh start included
    if (i_soft_reset) begin
      next_r = CORE_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous reset; soft reset is folded into the next-state logic
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and fault location
  assign o_busy           = r.busy;
  assign o_done           = r.flags.done;
  assign o_defect         = r.flags.defect;
  assign o_perr           = r.flags.perr;
  assign o_cpu_reset_ext  = r.flags.crst;
  assign o_crc_restricted = r.crc_restricted;
  assign o_fail_addr      = r.fail_addr;
  assign o_fail_data      = r.fail_data;

  // memory port
  assign o_mem_rd         = r.mem_rd;
  assign o_mem_wr         = r.mem_wr;
  assign o_mem_addr       = r.mem_addr;
  assign o_mem_wdata      = r.mem_wdata;

endmodule // mst_memory_self_test

// *** src/mst_pkg.sv ***
// Purpose: shared constants and types of the memory march self-test engine
// Assumes: one clock, synchronous active-high reset
// Notes:   element, phase and fault-word layout used by the core and the bench
package mst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // unit offsets used to classify the access that carries a command
  localparam logic [12:0] OFS_INT_LO = 13'h0000;
  localparam logic [12:0] OFS_INT_HI = 13'h0100;
  localparam logic [12:0] OFS_EXT_LO = 13'h0200;
  localparam logic [12:0] OFS_EXT_HI = 13'h1FFF;

  ////////////////////////////////////////////////////////////////////////////
  // error-handling mode codes; reserved codes behave as exit-on-error
  localparam logic [1:0] MODE_EXIT  = 2'h0;
  localparam logic [1:0] MODE_PAUSE = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // march elements, in execution order
  localparam logic [2:0] EL_FILL      = 3'h0;
  localparam logic [2:0] EL_DN_R0W1   = 3'h1;
  localparam logic [2:0] EL_UP_R1W0X2 = 3'h2;
  localparam logic [2:0] EL_UP_R1W0   = 3'h3;
  localparam logic [2:0] EL_UP_R0W1X2 = 3'h4;
  localparam logic [2:0] EL_FINAL     = 3'h5;

  // phase codes reported in the fault word
  localparam logic [2:0] PH_FILL  = 3'h0;
  localparam logic [2:0] PH_DN_R0 = 3'h1;
  localparam logic [2:0] PH_UP_R1 = 3'h2;
  localparam logic [2:0] PH_R1    = 3'h4;
  localparam logic [2:0] PH_UP_R0 = 3'h5;
  localparam logic [2:0] PH_FINAL = 3'h7;

  // fault word layout
  localparam int          FD_W      = 32;
  localparam int          FD_BI_LSB = 0;
  localparam int          FD_BI_W   = 8;
  localparam int          FD_PH_LSB = 8;
  localparam int          FD_PH_W   = 3;
  localparam logic [31:0] FD_RST    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FILL  = 3'h1,
    ST_READ  = 3'h2,
    ST_WAIT  = 3'h3,
    ST_CHECK = 3'h4,
    ST_WRITE = 3'h5,
    ST_PAUSE = 3'h6
  } mst_fsm_e;

  // status bits of the primary status register
  typedef struct packed {
    logic done;
    logic defect;
    logic perr;
    logic crst;
  } mst_flags_s;

  ////////////////////////////////////////////////////////////////////////////
  // value that the first read of an element expects
  function automatic logic first_val(input logic [2:0] el);
    return (el == EL_UP_R1W0X2) || (el == EL_UP_R1W0);
  endfunction

  // elements with a read/write/read/write body
  function automatic logic two_pairs(input logic [2:0] el);
    return (el == EL_UP_R1W0X2) || (el == EL_UP_R0W1X2);
  endfunction

  function automatic logic [2:0] phase_base(input logic [2:0] el);
    logic [2:0] ph;
    ph = PH_FINAL;
    unique case (el)
      EL_FILL:      ph = PH_FILL;
      EL_DN_R0W1:   ph = PH_DN_R0;
      EL_UP_R1W0X2: ph = PH_UP_R1;
      EL_UP_R1W0:   ph = PH_R1;
      EL_UP_R0W1X2: ph = PH_UP_R0;
      default:      ph = PH_FINAL;
    endcase
    return ph;
  endfunction

endpackage

// *** verif/memory_march_self_test_bench.sv ***
// Purpose: self-checking bench of the march self-test engine
// Assumes: stuck-at faults injected in the memory model
// Notes:   plain runs are table rows; pause, abort and flags by hand
`timescale 1ns/1ns
module memory_march_self_test_bench;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] len;
    logic [1:0]  mode;
    logic        prot;
    logic [12:0] ofs;
    logic        defect;
    logic        perr;
    logic        done;
    logic [31:0] faddr;
    logic [10:0] fdata;
  } mst_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        srst = 1'b0;
  logic        clr = 1'b0;
  logic        cset = 1'b0;
  logic        cclr = 1'b0;
  logic [12:0] ofs = 13'h0000;
  logic        prot = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] len = 32'h0;
  logic [1:0]  mode = 2'h0;
  logic        fen = 1'b0;
  logic [31:0] faddr = 32'h0;
  logic [4:0]  fbit = 5'h00;
  logic        fval = 1'b0;
  logic        busy, done, defect, perr, crst, crc, rd, wr;
  logic [31:0] fa, fd, ma, wd, rdata;
  int          failures = 0;
  int          compares = 0;
  // stuck-at-1 fails first in phase 1, stuck-at-0 in phase 2
  mst_row_s    rows [9] = '{
    '{32'h10, 32'h10, 2'h0, 1'h0, 13'h0000, 1'h0, 1'h0, 1'h1, 32'h00, 11'h000},
    '{32'h10, 32'h10, 2'h0, 1'h1, 13'h0200, 1'h0, 1'h1, 1'h1, 32'h00, 11'h000},
    '{32'h10, 32'h10, 2'h0, 1'h1, 13'h1FFF, 1'h0, 1'h1, 1'h1, 32'h00, 11'h000},
    '{32'h00, 32'h08, 2'h0, 1'h1, 13'h0100, 1'h0, 1'h0, 1'h1, 32'h00, 11'h000},
    '{32'h20, 32'h04, 2'h0, 1'h0, 13'h0300, 1'h0, 1'h0, 1'h1, 32'h00, 11'h000},
    '{32'h00, 32'h20, 2'h0, 1'h0, 13'h0000, 1'h1, 1'h0, 1'h1, 32'h14, 11'h11F},
    '{32'h10, 32'h13, 2'h3, 1'h0, 13'h0000, 1'h1, 1'h0, 1'h1, 32'h1C, 11'h200},
    '{32'h10, 32'h03, 2'h0, 1'h0, 13'h0000, 1'h0, 1'h0, 1'h1, 32'h00, 11'h000},
    '{32'h30, 32'h10, 2'h2, 1'h0, 13'h0000, 1'h1, 1'h0, 1'h1, 32'h3C, 11'h107}};

  always #20 clk = ~clk;

  mst_memory_self_test u_dut (
    .i_clk(clk), .i_reset(rst), .i_start(start), .i_soft_reset(srst),
    .i_clear_defect(clr), .i_crst_set(cset), .i_crst_clear(cclr), .i_cmd_offset(ofs),
    .i_protected(prot), .i_start_addr(addr), .i_length(len), .i_mode(mode),
    .o_busy(busy), .o_done(done), .o_defect(defect), .o_perr(perr),
    .o_cpu_reset_ext(crst), .o_crc_restricted(crc), .o_fail_addr(fa), .o_fail_data(fd),
    .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(ma), .o_mem_wdata(wd), .i_mem_rdata(rdata));
  mst_mem_model u_mem (
    .i_clk(clk), .i_rd(rd), .i_wr(wr), .i_addr(ma), .i_wdata(wd), .o_rdata(rdata),
    .i_flt_en(fen), .i_flt_addr(faddr), .i_flt_bit(fbit), .i_flt_val(fval));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // returns once idle or paused; a hang ends the run
  task automatic wait_ev;
    for (int k = 0; k < 20000; k++) begin
      if (!(busy === 1'b1 && defect !== 1'b1)) return;
      tick();
    end
    failures++;
    summarize();
  endtask
  task automatic go(input logic [31:0] a, input logic [31:0] l, input logic [1:0] m);
    addr = a;
    len = l;
    mode = m;
    pulse(start);
    wait_ev();
  endtask
  task automatic pause_run(input logic v, input logic [31:0] w, input logic [4:0] b);
    fen = 1'b1;
    faddr = w;
    fbit = b;
    fval = v;
    go(32'h0, 32'h10, 2'h1);
    for (int p = v ? 1 : 2; p <= 7; p += 2) begin
      chk("busy", 1'b1, busy);
      chk("done", 1'b0, done);
      chk("fail_data", {21'h0, p[2:0], p == 7 ? 8'h00 : {3'h0, b}}, fd);
      chk("fail_addr", w, fa);
      pulse(start);
      tick();
      chk("defect", 1'b1, defect);
      pulse(clr);
      chk("defect", 1'b0, defect);
      wait_ev();
    end
    chk("done", 1'b1, done);
    chk("defect", 1'b0, defect);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("busy", 1'b0, busy);
    chk("flags", 4'h0, {done, defect, perr, crst});
    chk("fail_data", 32'h0, fd);
    foreach (rows[i]) begin
      prot = rows[i].prot;
      ofs = rows[i].ofs;
      fen = rows[i].defect;
      faddr = rows[i].faddr;
      fbit = rows[i].fdata[4:0];
      fval = rows[i].fdata[10:8] == 3'h1;
      go(rows[i].addr, rows[i].len, rows[i].mode);
      chk("done", rows[i].done, done);
      chk("defect", rows[i].defect, defect);
      chk("perr", rows[i].perr, perr);
      if (rows[i].defect) begin
        chk("fail_addr", rows[i].faddr, fa);
        chk("fail_data", rows[i].fdata, fd);
      end
      tick();
    end
    prot = 1'b0;
    ofs = 13'h0000;
    pause_run(1'b1, 32'h08, 5'h05);
    pause_run(1'b0, 32'h04, 5'h1E);
    fen = 1'b0;
    addr = 32'h0;
    len = 32'h40;
    pulse(start);
    repeat (50) tick();
    pulse(srst);
    chk("busy", 1'b0, busy);
    chk("done", 1'b0, done);
    pulse(cset);
    prot = 1'b1;
    ofs = 13'h0300;
    tick();
    chk("crc", 1'b1, crc);
    pulse(cclr);
    chk("perr", 1'b1, perr);
    chk("crst", 1'b1, crst);
    ofs = 13'h0020;
    tick();
    pulse(cclr);
    chk("crst", 1'b0, crst);
    chk("crc", 1'b0, crc);
    summarize();
  end
endmodule // memory_march_self_test_bench

// *** verif/mst_checker.sv ***
// Purpose: port-level assertions of the march self-test engine
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every instance of the engine
`timescale 1ns/1ns
module mst_checker #(
  parameter int W  = 32,
  parameter int AW = 32
) (
  // inputs
  input wire logic          i_clk,
  input wire logic          i_reset,
  input wire logic          i_start,
  input wire logic          i_soft_reset,
  input wire logic          i_clear_defect,
  input wire logic          i_crst_set,
  input wire logic          i_crst_clear,
  input wire logic [12:0]   i_cmd_offset,
  input wire logic          i_protected,
  input wire logic [AW-1:0] i_start_addr,
  // outputs
  input wire logic          o_busy,
  input wire logic          o_done,
  input wire logic          o_defect,
  input wire logic          o_perr,
  input wire logic          o_cpu_reset_ext,
  input wire logic          o_crc_restricted,
  input wire logic [AW-1:0] o_fail_addr,
  input wire logic [31:0]   o_fail_data,
  input wire logic          o_mem_rd,
  input wire logic          o_mem_wr,
  input wire logic [AW-1:0] o_mem_addr,
  input wire logic [W-1:0]  o_mem_wdata
);
  logic pext;
  logic acc;
  logic pau;
  assign pext = i_protected && i_cmd_offset >= mst_pkg::OFS_EXT_LO
                && i_cmd_offset <= mst_pkg::OFS_EXT_HI;
  assign acc = i_start && !o_busy && !i_soft_reset;
  assign pau = o_busy && o_defect && !i_soft_reset;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_prot_refuse: assert property (
    acc && pext |=> o_perr && !o_busy)
    else $error("protected external start not refused");
  a_start_clears: assert property (
    acc && !pext |=> (o_busy || o_done) && !o_defect && !o_perr)
    else $error("start did not clear old flags");
  a_fill_first: assert property (
    $rose(o_busy) && !i_soft_reset |=> o_mem_wr && o_mem_wdata == '0
    && o_mem_addr == $past(i_start_addr, 2))
    else $error("first write is not zero at start address");
  // read strobe, wait, check, write state: the write strobe trails its read by three
  a_rw_same: assert property (
    o_mem_wr && $past(o_mem_rd, 3) |-> o_mem_addr == $past(o_mem_addr, 3))
    else $error("write went to another word than its read");
  a_end_done: assert property (
    $fell(o_busy) && !$past(i_soft_reset) && !$past(i_reset) |-> o_done)
    else $error("test ended without done");
  a_pause_hold: assert property (
    pau && !i_clear_defect |=> o_busy && o_defect && !o_done && !o_mem_rd && !o_mem_wr)
    else $error("paused test moved on or set done");
  // the pending write strobe comes one cycle after the flag drops
  a_pause_resume: assert property (
    pau && i_clear_defect |=> !o_defect
    ##1 (o_mem_wr || o_fail_data[10:8] == 3'h7 || $past(i_soft_reset)))
    else $error("paused test did not resume");
  a_soft_abort: assert property (
    i_soft_reset |=> !o_busy && !o_done && !o_defect && !o_perr && o_fail_data == '0)
    else $error("soft reset did not abort");
  a_crst_refuse: assert property (
    i_crst_clear && !i_crst_set && !i_start && !i_soft_reset && pext
    |=> o_perr && o_cpu_reset_ext == $past(o_cpu_reset_ext))
    else $error("protected reset-extension clear not refused");
  a_crc_limit: assert property (
    !$past(i_reset) && !$past(i_soft_reset) |-> o_crc_restricted == $past(pext))
    else $error("crc restriction does not follow protected external access");
  a_fault_word: assert property (
    $rose(o_defect) |-> o_fail_data[31:11] == '0 && o_fail_addr[1:0] == 2'h0
    && (o_fail_data[10:8] != 3'h7 || o_fail_data[7:0] == 8'h00)
    && o_fail_data[10:8] != 3'h0)
    else $error("fault word malformed");
  c_pause: cover property (o_busy && o_defect);
  c_resume: cover property (o_busy && o_defect && i_clear_defect);
  c_fail_done: cover property ($fell(o_busy) && o_done && o_defect);
  c_refused: cover property (o_perr && !o_busy);
endmodule // mst_checker

bind mst_memory_self_test mst_checker #(.W(W), .AW(AW)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_soft_reset(i_soft_reset),
  .i_clear_defect(i_clear_defect), .i_crst_set(i_crst_set), .i_crst_clear(i_crst_clear),
  .i_cmd_offset(i_cmd_offset), .i_protected(i_protected), .i_start_addr(i_start_addr),
  .o_busy(o_busy), .o_done(o_done), .o_defect(o_defect), .o_perr(o_perr),
  .o_cpu_reset_ext(o_cpu_reset_ext), .o_crc_restricted(o_crc_restricted),
  .o_fail_addr(o_fail_addr), .o_fail_data(o_fail_data), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata)
);

// *** verif/mst_mem_model.sv ***
// Purpose: behavioural memory on the far side of the self-test engine
// Assumes: read data is valid only in the cycle after the read strobe
// Notes:   one injectable stuck-at bit, applied on every read of its word
`timescale 1ns/1ns
module mst_mem_model (
  // memory port
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_rdata,
  // injected fault
  input  wire logic        i_flt_en,
  input  wire logic [31:0] i_flt_addr,
  input  wire logic [4:0]  i_flt_bit,
  input  wire logic        i_flt_val
);
  logic [31:0] mem [16];
  logic [31:0] q   = 32'hFFFF_FFFF;
  logic        vld = 1'b0;
  logic [31:0] rv;
  initial for (int k = 0; k < 16; k++) mem[k] = 32'hFFFF_FFFF;
  always_comb begin
    rv = mem[i_addr[5:2]];
    if (i_flt_en && i_addr == i_flt_addr) rv[i_flt_bit] = i_flt_val;
  end
  always @(posedge i_clk) begin
    vld <= i_rd;
    if (i_rd) q <= rv;
    if (i_wr) mem[i_addr[5:2]] <= i_wdata;
  end
  // outside the valid cycle show the inverse, so a late sample is caught
  assign o_rdata = vld ? q : ~q;
endmodule // mst_mem_model
